// ===== rtl/oes_pkg.sv
// shared constants and types for the output enable sequencer
package oes_pkg;

  localparam int          NUM_CHAN       = 3;
  localparam int          DELAY_W        = 22;
  // delays are in milliseconds; 0 to 3600 s
  localparam int          DELAY_MAX_S    = 3600;
  localparam int          MS_PER_S       = 1000;
  localparam logic [21:0] DELAY_MAX_MS   = 22'(DELAY_MAX_S * MS_PER_S);
  localparam logic [21:0] DELAY_RST_MS   = 22'h00_0000;
  // timer resolution and block clock
  localparam int          TICK_MS        = 1;
  localparam int          CLK_HZ         = 100_000_000;
  localparam int          TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  localparam int          TICK_W         = 17;
  // channel bit positions: low rail, positive rail, negative rail
  localparam int          LOW_RAIL_BIT   = 0;
  localparam int          POS_RAIL_BIT   = 1;
  localparam int          NEG_RAIL_BIT   = 2;
  localparam logic [2:0]  CHAN_ALL       = 3'h7;
  localparam logic [2:0]  CHAN_NONE      = 3'h0;
  localparam logic [2:0]  OUT_RST        = 3'h0;
  // non-volatile coupling value at power up
  localparam logic [2:0]  COUPLE_RST     = 3'h0;

  typedef enum logic [1:0] {
    OES_SD_OFF     = 2'b00,
    OES_SD_LATCHED = 2'b01,
    OES_SD_LIVE    = 2'b10
  } oes_sd_mode_type;

  typedef enum logic [1:0] {
    OES_PAIR_OFF      = 2'b00,
    OES_PAIR_PARALLEL = 2'b01,
    OES_PAIR_SERIES   = 2'b10,
    OES_PAIR_TRACKING = 2'b11
  } oes_pair_mode_type;

  // output on/off command, one-cycle valid
  typedef struct packed {
    logic       valid;
    logic       on;
    logic [2:0] chan;
  } oes_out_cmd_type;

  // delay programming, rise selects turn-on delay
  typedef struct packed {
    logic               valid;
    logic               rise;
    logic [2:0]         chan;
    logic [DELAY_W-1:0] ms;
  } oes_delay_wr_type;

  // generic masked strobe (coupling write, protection clear)
  typedef struct packed {
    logic       valid;
    logic [2:0] chan;
  } oes_mask_wr_type;

endpackage

// ===== rtl/oes_output_sequencer.sv
// output enable sequencer for three supply channels
// Notes on behaviour
// RQ1: outputs switch per command; state reads 0 off, 1 on; reset: all off
// RQ2: legacy mode switches all three together; general mode per channel
// RQ3: state readback shows commanded value even while a delay is pending
// RQ4: command to any coupled channel switches group, each with own delay
// RQ5: protection trip on one coupled channel shuts only that channel
// RQ6: on-couple and off-couple trigger pins switch the coupled group
// RQ7: exactly one coupled set; each write replaces it
// RQ8: coupling write forces all outputs off; coupling survives settings reset
// RQ9: turn-off delay 0..3600 s in 1 ms steps, reset 0, holds output on
// RQ10: protection shutdowns bypass the turn-off delay
// RQ11: turn-on delay 0..3600 s, 1 ms steps, applies to every off-to-on
// RQ12: asserted shutdown input disables outputs; commanded-off stay unaffected
// RQ13: latched mode: rising edge latches off until input false and cleared
// RQ14: live mode: enabled outputs follow the shutdown input level
// RQ15: off mode ignores shutdown input; power-up reset selects off
// RQ16: shutdown mode survives settings reset as non-volatile setting
// RQ17: host keeps coupling and tracking off in parallel or series pairing
// RQ18: protection clear releases trip latch; prior output state then returns
// RQ19: delays count 1 ms ticks; a new command restarts the pending delay
// RQ20: shutdown input synchronised before edge detect; one edge per assertion
module oes_output_sequencer #(
  parameter int TICK_CYCLES = oes_pkg::TICK_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      settings_reset,
  input  wire logic                      legacy_mode,
  input  wire oes_pkg::oes_out_cmd_type  out_cmd,
  input  wire oes_pkg::oes_delay_wr_type delay_wr,
  input  wire oes_pkg::oes_mask_wr_type  couple_wr,
  input  wire logic                      sd_mode_wr,
  input  wire oes_pkg::oes_sd_mode_type  sd_mode_in,
  input  wire logic                      pair_wr,
  input  wire oes_pkg::oes_pair_mode_type pair_mode_in,
  input  wire logic [2:0]                prot_trip,
  input  wire oes_pkg::oes_mask_wr_type  prot_clear,
  input  wire logic                      panel_clear,
  input  wire logic                      shutdown_input,
  input  wire logic                      couple_on_pin,
  input  wire logic                      couple_off_pin,
  output logic [2:0]                     out_enable,
  output logic [2:0]                     out_state,
  output logic [2:0]                     couple_set,
  output oes_pkg::oes_sd_mode_type       sd_mode,
  output oes_pkg::oes_pair_mode_type     pair_mode,
  output logic                           latched_shutdown_status,
  output logic [2:0]                     trip_status
);

  localparam logic [oes_pkg::TICK_W-1:0] TICK_LAST =
    oes_pkg::TICK_W'(TICK_CYCLES - 1);

  // pin synchronisers: stage one feeds stage two only
  logic       sd_meta;
  logic       sd_sync;
  logic       sd_prev;
  logic [1:0] cpl_meta;
  logic [1:0] cpl_sync;
  logic [1:0] cpl_prev;

  logic [oes_pkg::TICK_W-1:0] tick_cnt;
  logic                       tick;

  logic [oes_pkg::DELAY_W-1:0] rise_ms [oes_pkg::NUM_CHAN];
  logic [oes_pkg::DELAY_W-1:0] fall_ms [oes_pkg::NUM_CHAN];

  logic [oes_pkg::DELAY_W-1:0] clipped_ms;
  logic [2:0]                  cmd_mask;
  logic [2:0]                  pin_on_mask;
  logic [2:0]                  pin_off_mask;
  logic [2:0]                  restart;
  logic [2:0]                  next_state;
  logic                        sd_edge;
  logic                        sd_block;
  logic                        clear_any;
  logic                        force_all_off;
  logic [2:0]                  want;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sd_meta  <= 1'b0;
      sd_sync  <= 1'b0;
      sd_prev  <= 1'b0;
      cpl_meta <= 2'b00;
      cpl_sync <= 2'b00;
      cpl_prev <= 2'b00;
    end else begin
      sd_meta  <= shutdown_input;
      sd_sync  <= sd_meta;                       // RQ20
      sd_prev  <= sd_sync;
      cpl_meta <= {couple_off_pin, couple_on_pin};
      cpl_sync <= cpl_meta;
      cpl_prev <= cpl_sync;
    end
  end

  // free-running millisecond tick shared by all channel timers
  // sharing one tick costs up to one tick of jitter on every delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_LAST) begin
      tick_cnt <= '0;
      tick     <= 1'b1;                          // RQ19
    end else begin
      tick_cnt <= tick_cnt + oes_pkg::TICK_W'(1);
      tick     <= 1'b0;
    end
  end

  always_comb begin
    sd_edge      = sd_sync && !sd_prev;          // RQ20
    clear_any    = prot_clear.valid || panel_clear;
    pin_on_mask  = (cpl_sync[0] && !cpl_prev[0]) ? couple_set : 3'h0; // RQ6
    pin_off_mask = (cpl_sync[1] && !cpl_prev[1]) ? couple_set : 3'h0; // RQ6
    cmd_mask     = 3'h0;
    if (out_cmd.valid) begin
      if (legacy_mode) begin
        cmd_mask = oes_pkg::CHAN_ALL;            // RQ2
      end else if ((out_cmd.chan & couple_set) != 3'h0) begin
        cmd_mask = out_cmd.chan | couple_set;    // RQ4
      end else begin
        cmd_mask = out_cmd.chan;                 // RQ2
      end
    end
    next_state = out_state;
    next_state = next_state & ~pin_off_mask;
    next_state = next_state | pin_on_mask;
    if (out_cmd.on) begin
      next_state = next_state | cmd_mask;        // RQ1
    end else begin
      next_state = next_state & ~cmd_mask;       // RQ1
    end
    restart       = cmd_mask | pin_on_mask | pin_off_mask; // RQ19
    force_all_off = couple_wr.valid || settings_reset;     // RQ8
    clipped_ms    = (delay_wr.ms > oes_pkg::DELAY_MAX_MS) ?
                    oes_pkg::DELAY_MAX_MS : delay_wr.ms;
  end

  // what each channel timer chases once blocking is applied
  always_comb begin
    // live mode follows level, latched mode holds until cleared
    sd_block = latched_shutdown_status ||
               (sd_mode == oes_pkg::OES_SD_LIVE && sd_sync);  // RQ14
    // commanded-off channels are untouched by shutdown and stay off
    want = out_state & ~trip_status & ~{3{sd_block}};        // RQ12
  end

  // commanded configuration, which is what state readback shows
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_state <= oes_pkg::OUT_RST;             // RQ1
    end else if (force_all_off) begin
      out_state <= oes_pkg::OUT_RST;             // RQ8
    end else begin
      out_state <= next_state;                   // RQ3
    end
  end

  // non-volatile settings: only power-up reset touches them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      couple_set <= oes_pkg::COUPLE_RST;
      sd_mode    <= oes_pkg::OES_SD_OFF;         // RQ15
    end else begin
      if (couple_wr.valid) begin
        couple_set <= couple_wr.chan;            // RQ7
      end
      if (sd_mode_wr) begin
        sd_mode <= sd_mode_in;                   // RQ16
      end
    end
  end

  // pairing is stored only; the host keeps it consistent with coupling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pair_mode <= oes_pkg::OES_PAIR_OFF;
    end else if (settings_reset) begin
      pair_mode <= oes_pkg::OES_PAIR_OFF;        // RQ17
    end else if (pair_wr) begin
      pair_mode <= pair_mode_in;
    end
  end

  // latched shutdown: a new edge wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_shutdown_status <= 1'b0;
    end else if (sd_mode == oes_pkg::OES_SD_LATCHED && sd_edge) begin
      latched_shutdown_status <= 1'b1;           // RQ13
    end else if (sd_mode != oes_pkg::OES_SD_LATCHED) begin
      latched_shutdown_status <= 1'b0;           // RQ15
    end else if (clear_any && !sd_sync) begin
      latched_shutdown_status <= 1'b0;           // RQ13
    end
  end

  // protection trip latch per channel; trip wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_status <= 3'h0;
    end else if (prot_clear.valid) begin
      trip_status <= (trip_status & ~prot_clear.chan) | prot_trip; // RQ18
    end else if (panel_clear) begin
      trip_status <= prot_trip;                  // RQ18
    end else begin
      trip_status <= trip_status | prot_trip;    // RQ5
    end
  end

  // delay programming, values above the maximum are clipped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < oes_pkg::NUM_CHAN; i++) begin
        rise_ms[i] <= oes_pkg::DELAY_RST_MS;     // RQ11
        fall_ms[i] <= oes_pkg::DELAY_RST_MS;     // RQ9
      end
    end else begin
      for (int i = 0; i < oes_pkg::NUM_CHAN; i++) begin
        if (settings_reset) begin
          rise_ms[i] <= oes_pkg::DELAY_RST_MS;   // RQ11
          fall_ms[i] <= oes_pkg::DELAY_RST_MS;   // RQ9
        end else if (delay_wr.valid && delay_wr.chan[i]) begin
          if (delay_wr.rise) begin
            rise_ms[i] <= clipped_ms;            // RQ11
          end else begin
            fall_ms[i] <= clipped_ms;            // RQ9
          end
        end
      end
    end
  end

  // per-channel sequencing timer and physical enable
  for (genvar g = 0; g < oes_pkg::NUM_CHAN; g++) begin : g_chan
    logic immediate_off;

    // protection, shutdown and coupling writes cut power without delay
    assign immediate_off = trip_status[g] || prot_trip[g] || sd_block ||
                           force_all_off;        // RQ10

    oes_chan_timer #(
      .DELAY_W(oes_pkg::DELAY_W)
    ) u_timer (
      .clk          (clk),
      .rst_n        (rst_n),
      .tick         (tick),
      .want         (want[g]),
      .restart      (restart[g]),
      .immediate_off(immediate_off),
      .rise_ms      (rise_ms[g]),
      .fall_ms      (fall_ms[g]),
      .phys         (out_enable[g])
    );
  end

endmodule // oes_output_sequencer

// one channel's sequencing timer and physical enable
module oes_chan_timer #(
  parameter int DELAY_W = oes_pkg::DELAY_W
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               tick,
  input  wire logic               want,
  input  wire logic               restart,
  input  wire logic               immediate_off,
  input  wire logic [DELAY_W-1:0] rise_ms,
  input  wire logic [DELAY_W-1:0] fall_ms,
  output logic                    phys
);

  logic               target;
  logic [DELAY_W-1:0] remain;

  // goal is reloaded before counting, so a zero delay still costs two cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target <= 1'b0;
      phys   <= 1'b0;                            // RQ1
      remain <= '0;
    end else if (immediate_off) begin
      target <= 1'b0;
      phys   <= 1'b0;                            // RQ10
      remain <= '0;
    end else if (restart || want != target) begin
      // reload on any change of goal, including a repeated command
      target <= want;                            // RQ19
      remain <= want ? rise_ms : fall_ms;        // RQ11
    end else if (phys != target) begin
      if (remain == '0) begin
        phys <= target;                          // RQ9
      end else if (tick) begin
        remain <= remain - DELAY_W'(1);          // RQ19
      end
    end
  end

endmodule // oes_chan_timer

// ===== verif/oes_output_sequencer_chk.sv
// assertion checker bound to the output enable sequencer
module oes_seq_chk (
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire logic                      settings_reset,
  input wire logic                      legacy_mode,
  input wire oes_pkg::oes_out_cmd_type  out_cmd,
  input wire oes_pkg::oes_mask_wr_type  couple_wr,
  input wire logic                      sd_mode_wr,
  input wire logic [2:0]                prot_trip,
  input wire logic                      shutdown_input,
  input wire logic [2:0]                out_enable,
  input wire logic [2:0]                out_state,
  input wire logic [2:0]                couple_set,
  input wire oes_pkg::oes_sd_mode_type  sd_mode,
  input wire logic                      latched_shutdown_status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire plain = !settings_reset && !couple_wr.valid;
  property p_rst;
    $rose(rst_n) |-> out_enable == 0 && out_state == 0 && couple_set == 0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs on after reset");
  property p_srst_off;
    settings_reset |=> out_state == 3'h0;
  endproperty
  a_srst_off: assert property (p_srst_off) else $error("state kept");
  property p_srst_keep;
    settings_reset && !couple_wr.valid && !sd_mode_wr
      |=> $stable(couple_set) && $stable(sd_mode);
  endproperty
  a_srst_keep: assert property (p_srst_keep) else $error("nv lost");
  property p_legacy;
    out_cmd.valid && out_cmd.on && legacy_mode && plain |=> out_state == 3'h7;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy not all");
  property p_cmd;
    out_cmd.valid && !legacy_mode && plain && !(|(out_cmd.chan & couple_set))
      |=> out_state == ($past(out_cmd.on) ?
                        $past(out_state) | $past(out_cmd.chan) :
                        $past(out_state) & ~$past(out_cmd.chan));
  endproperty
  a_cmd: assert property (p_cmd) else $error("readback wrong");
  property p_cpl;
    couple_wr.valid |=> couple_set == $past(couple_wr.chan) && out_state == 0
      ##1 out_enable == 3'h0;
  endproperty
  a_cpl: assert property (p_cpl) else $error("coupling write");
  property p_trip;
    prot_trip != 0 |=> (out_enable & $past(prot_trip)) == 3'h0;
  endproperty
  a_trip: assert property (p_trip) else $error("trip delayed");
  property p_lat;
    latched_shutdown_status ##1 latched_shutdown_status |-> out_enable == 0;
  endproperty
  a_lat: assert property (p_lat) else $error("latched but on");
  property p_live;
    (sd_mode == oes_pkg::OES_SD_LIVE && shutdown_input)[*6]
      |-> out_enable == 0;
  endproperty
  a_live: assert property (p_live) else $error("live not off");
  property p_offmode;
    (sd_mode == oes_pkg::OES_SD_OFF)[*2] |-> !latched_shutdown_status;
  endproperty
  a_offmode: assert property (p_offmode) else $error("off mode latch");
  c_lat: cover property (latched_shutdown_status);
  c_trip: cover property (prot_trip != 0 && out_enable != 0);
  c_cpl: cover property (couple_wr.valid);
endmodule // oes_seq_chk

bind oes_output_sequencer oes_seq_chk u_chk (
  .clk                    (clk),
  .rst_n                  (rst_n),
  .settings_reset         (settings_reset),
  .legacy_mode            (legacy_mode),
  .out_cmd                (out_cmd),
  .couple_wr              (couple_wr),
  .sd_mode_wr             (sd_mode_wr),
  .prot_trip              (prot_trip),
  .shutdown_input         (shutdown_input),
  .out_enable             (out_enable),
  .out_state              (out_state),
  .couple_set             (couple_set),
  .sd_mode                (sd_mode),
  .latched_shutdown_status(latched_shutdown_status)
);

// ===== verif/oes_pin_source.sv
// external shutdown and couple trigger pin source
module oes_pin_source (
  input  wire logic clk,
  input  wire logic sd_req,
  input  wire logic on_req,
  input  wire logic off_req,
  output logic      shutdown_input,
  output logic      couple_on_pin,
  output logic      couple_off_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {shutdown_input, couple_on_pin, couple_off_pin} = 3'h0;
  // pins move 3 ns after each falling edge, away from the sampling edge
  always @(negedge clk) begin
    #3;
    {shutdown_input, couple_on_pin, couple_off_pin} <=
      {sd_req, on_req, off_req};
  end
endmodule // oes_pin_source

// ===== verif/oes_output_sequencer_bench.sv
// self-checking bench for the output enable sequencer
module oes_output_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  `define OES_CHK(g, x) begin num_checks++; if ((g) !== (x)) begin \
    error_cnt++; $display("Error %0t: got %h exp %h", $time, g, x); end end
  logic                       clk, rst_n, srst, leg, sd_wr, pr_wr, pclr, look;
  logic                       sd_req, on_req, off_req, sdi, onp, offp, lat;
  oes_pkg::oes_out_cmd_type   cmd;
  oes_pkg::oes_delay_wr_type  dly;
  oes_pkg::oes_mask_wr_type   cpl, clr;
  oes_pkg::oes_sd_mode_type   sdm_in, sdm;
  oes_pkg::oes_pair_mode_type pm_in, pm;
  logic [2:0]                 trip, oen, ost, cset, tst, m;
  logic [16:0]                q[$];
  logic [16:0]                e;
  int                         error_cnt, num_checks, cyc_cnt;
  wire  [15:0]                w0 = {6'h00, lat, tst, oen, ost};
  wire  [15:0]                w1 = {9'h000, cset, sdm, pm};
  oes_output_sequencer #(.TICK_CYCLES(4)) uut (.clk(clk), .rst_n(rst_n),
    .settings_reset(srst), .legacy_mode(leg), .out_cmd(cmd), .delay_wr(dly),
    .couple_wr(cpl), .sd_mode_wr(sd_wr), .sd_mode_in(sdm_in), .pair_wr(pr_wr),
    .pair_mode_in(pm_in), .prot_trip(trip), .prot_clear(clr),
    .panel_clear(pclr), .shutdown_input(sdi), .couple_on_pin(onp),
    .couple_off_pin(offp), .out_enable(oen), .out_state(ost),
    .couple_set(cset), .sd_mode(sdm), .pair_mode(pm),
    .latched_shutdown_status(lat), .trip_status(tst));
  oes_pin_source src (.clk(clk), .sd_req(sd_req), .on_req(on_req),
    .off_req(off_req), .shutdown_input(sdi), .couple_on_pin(onp),
    .couple_off_pin(offp));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic cy(int n); repeat (n) @(negedge clk); endtask
  task automatic note(logic s, logic [15:0] v);
    q.push_back({s, v});
    look = 1;
    cy(1);
    look = 0;
  endtask
  task automatic go(logic on, logic [2:0] k);
    cmd = '{1'b1, on, k};
    cy(1);
    cmd.valid = 0;
    cy(3);
  endtask
  task automatic sdmode(oes_pkg::oes_sd_mode_type v);
    sdm_in = v;
    sd_wr = 1;
    cy(1);
    sd_wr = 0;
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // monitor: compares the oldest note with what the outputs show
  always @(posedge clk) if (look) begin
    e = q.pop_front();
    `OES_CHK(e[16] ? w1 : w0, e[15:0])
  end
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      error_cnt++;
      $display("Error %0t: timeout", $time);
      give_verdict();
    end
  end
  initial begin
    {rst_n, srst, leg, sd_wr, pr_wr, pclr, sd_req, on_req, off_req} = 0;
    {look, cmd, dly, cpl, clr, trip} = 0;
    sdm_in = oes_pkg::OES_SD_OFF;
    pm_in = oes_pkg::OES_PAIR_OFF;
    void'($urandom(32'hf103));
    cy(10); rst_n = 1; cy(1);
    note(0, 16'h0000);
    note(1, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      pm_in = oes_pkg::oes_pair_mode_type'(i); pr_wr = 1; cy(1); pr_wr = 0;
      note(1, 16'(i));
    end
    srst = 1; cy(1); srst = 0;
    note(1, 16'h0000);
    $display("reset and pairing done");
    m = 3'($urandom_range(1, 7));
    go(1, m); note(0, {10'h000, m, m});
    go(0, 3'h5); note(0, {10'h000, m & 3'h2, m & 3'h2});
    leg = 1; go(1, 3'h2); note(0, 16'h003f);
    go(0, 3'h1); note(0, 16'h0000);
    leg = 0;
    go(1, 3'h4); cpl = '{1'b1, 3'h3}; cy(1); cpl.valid = 0; cy(2);
    note(0, 16'h0000);
    note(1, 16'h0030);
    go(1, 3'h1); note(0, 16'h001b);
    off_req = 1; cy(3); off_req = 0; cy(5); note(0, 16'h0000);
    on_req = 1; cy(3); on_req = 0; cy(5); note(0, 16'h001b);
    $display("mode and coupling done");
    sdmode(oes_pkg::OES_SD_LIVE);
    go(1, 3'h7); sd_req = 1; cy(8); note(0, 16'h0007);
    sd_req = 0; cy(8); note(0, 16'h003f);
    sdmode(oes_pkg::OES_SD_LATCHED);
    sd_req = 1; cy(8); sd_req = 0; cy(8); note(0, 16'h0207);
    clr = '{1'b1, 3'h0}; cy(1); clr.valid = 0; cy(4);
    note(0, 16'h003f);
    srst = 1; cy(1); srst = 0; note(1, 16'h0034);
    sdmode(oes_pkg::OES_SD_OFF);
    go(1, 3'h7); sd_req = 1; cy(8); note(0, 16'h003f);
    sd_req = 0;
    $display("shutdown done");
    dly = '{1'b1, 1'b1, 3'h4, 22'd5}; cy(1);
    dly = '{1'b1, 1'b0, 3'h7, 22'd50}; cy(1); dly.valid = 0;
    trip = 3'h2; cy(1); trip = 0; cy(1); note(0, 16'h00af);
    pclr = 1; cy(1); pclr = 0; cy(4); note(0, 16'h003f);
    go(0, 3'h4); note(0, 16'h003b);
    cy(210); note(0, 16'h001b);
    go(1, 3'h4); note(0, 16'h001f);
    cy(30); note(0, 16'h003f);
    trip = 3'h1; cy(1); trip = 0; cy(1); note(0, 16'h0077);
    clr = '{1'b1, 3'h1}; cy(1); clr.valid = 0; cy(4);
    note(0, 16'h003f);
    $display("delay and trip done");
    cy(2);
    give_verdict();
  end
endmodule // oes_output_sequencer_bench
